/* File: dcs_ctrl.sv */
`include "dcs_params.svh"

module dcs_ctrl
   import dcs_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // host function channel
   input  wire logic        fn_valid,
   input  wire logic [7:0]  fn_code,
   input  wire logic [7:0]  fn_reg,
   input  wire logic [15:0] fn_data,
   output      logic        fn_reply,
   output      logic        fn_reject,
   output      logic [15:0] fn_rdata,
   // interrupt sources and keyboard, asynchronous pins
   input  wire logic [15:6] src_event,
   input  wire logic [15:0] kbd_code,
   // interrupt request
   output      logic        irq
);

   localparam int SRC_W = `DCS_SRC_HI - `DCS_SRC_LO + 1;

   dcs_word_t        status;
   dcs_word_t        enable;
   dcs_word_t        next_status;
   dcs_word_t        next_enable;
   dcs_word_t        scratch [`DCS_SCRATCH_COUNT];
   dcs_word_t        instr   [3];
   dcs_word_t        kbd_meta;
   dcs_word_t        kbd_sync;
   logic [SRC_W-1:0] src_meta;
   logic [SRC_W-1:0] src_sync;
   logic [SRC_W-1:0] src_last;
   dcs_word_t        set_bits;
   dcs_word_t        clr_bits;
   logic             is_load;
   logic             is_unload;
   logic             is_disable;
   logic             is_reset;
   dcs_word_t        read_word;
   logic             read_ok;
   dcs_step_if       st ();

   // 0 scratchpad, 1 status, 2 enable, 3 keyboard, 4 step position, 5 instruction, 7 none
   function automatic logic [2:0] reg_kind(input logic [7:0] num);
      if (num < 8'(`DCS_SCRATCH_COUNT)) begin
         reg_kind = 3'h0;
      end else if (num == `DCS_REG_STATUS) begin
         reg_kind = 3'h1;
      end else if (num == `DCS_REG_ENABLE) begin
         reg_kind = 3'h2;
      end else if (num == `DCS_REG_KEYBOARD) begin
         reg_kind = 3'h3;
      end else if (num == `DCS_REG_STEP_POS) begin
         reg_kind = 3'h4;
      end else if (num >= `DCS_REG_INSTR_BASE && num < `DCS_REG_INSTR_BASE + 8'h03) begin
         reg_kind = 3'h5;
      end else begin
         reg_kind = 3'h7;
      end
   endfunction

   assign is_load    = fn_valid && fn_code == `DCS_FN_LOAD;
   assign is_unload  = fn_valid && fn_code == `DCS_FN_UNLOAD;
   assign is_disable = fn_valid && fn_code == `DCS_FN_DISABLE;
   assign is_reset   = fn_valid && fn_code == `DCS_FN_RESET;

   // pins cross in through two flops; only the second is looked at
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         src_meta <= '0;
         src_sync <= '0;
         src_last <= '0;
         kbd_meta <= 16'h0000;
         kbd_sync <= 16'h0000;
      end else begin
         src_meta <= src_event;
         src_sync <= src_meta;
         src_last <= src_sync;
         kbd_meta <= kbd_code;
         kbd_sync <= kbd_meta;
      end
   end

   // rising edge of each source flags the status bit of the same number, which for bit 6 is shared with step completion
   always_comb begin
      set_bits = 16'h0000;
      set_bits[`DCS_SRC_HI:`DCS_SRC_LO] = src_sync & ~src_last;
      if (st.done) begin
         set_bits[`DCS_DONE_BIT] = 1'b1;
      end
   end

   // all three clearing paths; a new event in the same cycle survives
   always_comb begin
      clr_bits = 16'h0000;
      if (is_unload && (reg_kind(fn_reg) == 3'h1 || reg_kind(fn_reg) == 3'h3)) begin
         clr_bits = 16'hFFFF;
      end
      if (is_disable) begin
         clr_bits = clr_bits | fn_data;
      end
      if (is_reset) begin
         clr_bits = 16'hFFFF;
      end
      next_status = (status & ~clr_bits) | set_bits;
      next_status[`DCS_SRC_LO-1:0] = 6'h00;
   end

   // enable register: load sets the mask, disable and reset knock bits out
   always_comb begin
      next_enable = enable;
      if (is_load && reg_kind(fn_reg) == 3'h2) begin
         next_enable = fn_data;
      end
      if (is_disable) begin
         next_enable = enable & ~fn_data;
      end
      if (is_reset) begin
         next_enable = `DCS_ENABLE_RESET;
      end
      next_enable[`DCS_SRC_LO-1:0] = 6'h00;
   end

   // status and mask, with the request built from the same next values
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status <= `DCS_STATUS_RESET;
         enable <= `DCS_ENABLE_RESET;
         irq    <= 1'b0;
      end else begin
         status <= next_status;
         enable <= next_enable;
         irq    <= |(next_status & next_enable);
      end
   end

   // scratchpad bank, one full word per register, no masking of any bit
   generate
      for (genvar i = 0; i < `DCS_SCRATCH_COUNT; i++) begin : g_scratch
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               scratch[i] <= 16'h0000;
            end else if (is_load && fn_reg == 8'(i)) begin
               scratch[i] <= fn_data;
            end
         end
      end
      for (genvar j = 0; j < 3; j++) begin : g_instr
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               instr[j] <= 16'h0000;
            end else if (is_load && fn_reg == `DCS_REG_INSTR_BASE + 8'(j)) begin
               instr[j] <= fn_data;
            end
         end
      end
   endgenerate

   // instruction length in word 0 top bits; zero is taken as one word
   always_comb begin
      st.length   = (instr[0][15:14] == 2'h0) ? 2'h1 : instr[0][15:14];
      if (st.length == 2'h3 || instr[0][15:14] == 2'h3) begin
         st.length = 2'h3;
      end
      st.go_pulse = fn_valid && fn_code == `DCS_FN_CLK_STEP;
      st.go_instr = fn_valid && fn_code == `DCS_FN_INSTR_STEP;
   end

   dcs_step_engine u_step (
      .clk   (clk),
      .rst_n (rst_n),
      .st    (st.engine)
   );

   // read mux for unloads
   always_comb begin
      read_word = 16'h0000;
      read_ok   = 1'b1;
      case (reg_kind(fn_reg))
         3'h0: read_word = scratch[fn_reg[3:0]];
         3'h1: read_word = status;
         3'h2: read_word = enable;
         3'h3: read_word = kbd_sync;
         3'h4: read_word = st.active ? {2'h0, st.word, st.pulse} : `DCS_POS_IDLE;
         3'h5: read_word = instr[2'(fn_reg - `DCS_REG_INSTR_BASE)];
         default: read_ok = 1'b0;
      endcase
   end

   // one reply per accepted function; unknown codes or registers are rejected
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fn_reply  <= 1'b0;
         fn_reject <= 1'b0;
         fn_rdata  <= 16'h0000;
      end else begin
         fn_reply  <= 1'b0;
         fn_reject <= 1'b0;
         if (fn_valid) begin
            if (is_unload && read_ok) begin
               fn_rdata <= read_word;
               fn_reply <= 1'b1;
            end else if ((is_load && read_ok && reg_kind(fn_reg) != 3'h1
                          && reg_kind(fn_reg) != 3'h4) || is_disable || is_reset
                          || fn_code == `DCS_FN_CLK_STEP || fn_code == `DCS_FN_INSTR_STEP) begin
               fn_reply <= 1'b1;
            end else begin
               fn_reject <= 1'b1;
            end
         end
      end
   end

   a_irq_has_status: assert property (@(posedge clk) disable iff (!rst_n)
      irq |-> (status != 16'h0000))
      else $error("interrupt raised with status zero");

   a_irq_gated_mask: assert property (@(posedge clk) disable iff (!rst_n)
      irq == |(status & enable))
      else $error("interrupt not equal to status and mask");

   a_unload_clears: assert property (@(posedge clk) disable iff (!rst_n)
      (is_unload && fn_reg == `DCS_REG_STATUS && set_bits == 16'h0000)
      |=> (status == 16'h0000) && fn_reply && (fn_rdata == $past(status)))
      else $error("status unload did not clear status");

   a_disable_clears: assert property (@(posedge clk) disable iff (!rst_n)
      is_disable |=> ((status & $past(fn_data) & ~$past(set_bits)) == 16'h0000)
      && ((enable & $past(fn_data)) == 16'h0000))
      else $error("disable left matching bits set");

   a_reset_fn: assert property (@(posedge clk) disable iff (!rst_n)
      (is_reset && set_bits == 16'h0000) |=> status == 16'h0000 && fn_reply)
      else $error("reset function did not clear and reply");

   a_enable_zero: assert property (@(posedge clk) disable iff (!rst_n)
      is_reset |=> (enable == 16'h0000))
      else $error("enable not zero after reset");

   a_scratch_back: assert property (@(posedge clk) disable iff (!rst_n)
      (is_load && fn_reg < 8'h10) ##1 !fn_valid
      ##1 (is_unload && fn_reg == $past(fn_reg, 2))
      |=> fn_reply && fn_rdata == $past(fn_data, 3))
      else $error("scratchpad did not return loaded word");

   a_scratch_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (is_load && fn_reg < 8'h10 && fn_data == 16'h0000)
      |=> scratch[$past(fn_reg[3:0])] == 16'h0000)
      else $error("scratchpad bit stuck at one");

   a_status_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
      status[`DCS_SRC_LO-1:0] == 6'h00)
      else $error("unused status bits set");

   a_step_pos_idle: assert property (@(posedge clk) disable iff (!rst_n)
      (is_unload && fn_reg == `DCS_REG_STEP_POS && !st.active) |=> fn_rdata == 16'hFFFF)
      else $error("idle step position not all ones");

   // the keyboard unload clears status on the same path as the status unload
   a_kbd_unload_clears: assert property (@(posedge clk) disable iff (!rst_n)
      (is_unload && fn_reg == `DCS_REG_KEYBOARD && set_bits == 16'h0000)
      |=> (status == 16'h0000))
      else $error("keyboard unload did not clear status");

   // every request draws exactly one answer, never both
   a_one_answer: assert property (@(posedge clk) disable iff (!rst_n)
      fn_valid |=> (fn_reply != fn_reject))
      else $error("request without exactly one answer");

   // a source edge lands in status even when a clear falls in the same cycle
   a_event_sets_status: assert property (@(posedge clk) disable iff (!rst_n)
      (set_bits != 16'h0000) |=> ((status & $past(set_bits)) == $past(set_bits)))
      else $error("event lost from status");

   // completion of a stepped instruction shows up in the status word
   a_done_sets_status: assert property (@(posedge clk) disable iff (!rst_n)
      st.done |=> status[`DCS_DONE_BIT])
      else $error("step completion left status bit clear");

   // a running position shows word 0, 1 or 2 in its upper field
   a_pos_word_range: assert property (@(posedge clk) disable iff (!rst_n)
      (is_unload && fn_reg == `DCS_REG_STEP_POS && st.active)
      |=> (fn_rdata[15:14] == 2'h0) && (fn_rdata[13:12] != 2'h3))
      else $error("step position word number out of range");

   // status is only ever cleared by the host, so a load of it is refused
   a_status_load_refused: assert property (@(posedge clk) disable iff (!rst_n)
      (is_load && fn_reg == `DCS_REG_STATUS) |=> fn_reject && !fn_reply)
      else $error("load of status was not refused");

   // the disable load is answered like any other function
   a_disable_replies: assert property (@(posedge clk) disable iff (!rst_n)
      is_disable |=> fn_reply)
      else $error("disable load not answered");
endmodule

/* File: dcs_params.svh */
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH

// register numbers on the function channel
`define DCS_REG_STATUS     8'h20
`define DCS_REG_ENABLE     8'h21
`define DCS_REG_KEYBOARD   8'h22
`define DCS_REG_STEP_POS   8'h23
`define DCS_REG_INSTR_BASE 8'h24
`define DCS_SCRATCH_COUNT  16

// function codes
`define DCS_FN_LOAD        8'h10
`define DCS_FN_UNLOAD      8'h11
`define DCS_FN_DISABLE     8'h1A
`define DCS_FN_RESET       8'h30
`define DCS_FN_CLK_STEP    8'h40
`define DCS_FN_INSTR_STEP  8'h41

// status field layout and reset values
`define DCS_SRC_LO         6
`define DCS_SRC_HI         15
`define DCS_DONE_BIT       6
`define DCS_STATUS_RESET   16'h0000
`define DCS_ENABLE_RESET   16'h0000
`define DCS_POS_IDLE       16'hFFFF

// clock pulses making up one instruction word
`define DCS_PULSES_PER_WORD 12'h004

`endif

/* File: dcs_pkg.sv */
package dcs_pkg;
   typedef enum logic [1:0] {
      DCS_IDLE = 2'b00,
      DCS_HOLD = 2'b01,
      DCS_RUN  = 2'b10
   } dcs_step_e;

   typedef logic [15:0] dcs_word_t;
endpackage

/* File: dcs_step_if.sv */
interface dcs_step_if;
   logic        go_pulse;
   logic        go_instr;
   logic [1:0]  length;
   logic [1:0]  word;
   logic [11:0] pulse;
   logic        active;
   logic        done;

   modport ctrl   (output go_pulse, go_instr, length, input word, pulse, active, done);
   modport engine (input go_pulse, go_instr, length, output word, pulse, active, done);
endinterface

/* File: dcs_step_engine.sv */
`include "dcs_params.svh"

module dcs_step_engine
   import dcs_pkg::*;
(
   // clock and reset
   input wire logic  clk,
   input wire logic  rst_n,
   // step control
   dcs_step_if.engine st
);

   dcs_step_e state;
   logic      last_pulse;
   logic      last_word;

   assign last_pulse = (st.pulse == `DCS_PULSES_PER_WORD - 12'h001);
   assign last_word  = (st.word == st.length - 2'h1);
   assign st.active  = (state != DCS_IDLE);

   // walk pulse by pulse through each word; hold mode waits for the next clock step
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state   <= DCS_IDLE;
         st.word  <= 2'h0;
         st.pulse <= 12'h000;
         st.done  <= 1'b0;
      end else begin
         st.done <= 1'b0;
         case (state)
            DCS_IDLE: begin
               st.word  <= 2'h0;
               st.pulse <= 12'h000;
               if (st.go_instr) begin
                  state <= DCS_RUN;
               end else if (st.go_pulse) begin
                  state <= DCS_HOLD;
               end
            end
            DCS_HOLD, DCS_RUN: begin
               if (state == DCS_RUN || st.go_pulse || st.go_instr) begin
                  if (st.go_instr) begin
                     state <= DCS_RUN;
                  end
                  if (last_pulse) begin
                     st.pulse <= 12'h000;
                     if (last_word) begin
                        state   <= DCS_IDLE;
                        st.done <= 1'b1;
                     end else begin
                        st.word <= st.word + 2'h1;
                     end
                  end else begin
                     st.pulse <= st.pulse + 12'h001;
                  end
               end
            end
            default: state <= DCS_IDLE;
         endcase
      end
   end

   // word index never runs past the instruction length
   a_word_in_range: assert property (@(posedge clk) disable iff (!rst_n)
      st.active |-> (st.word < st.length))
      else $error("word index beyond instruction length");

   // a clock step in hold mode moves exactly one pulse
   a_one_pulse_step: assert property (@(posedge clk) disable iff (!rst_n)
      (state == DCS_HOLD && st.go_pulse && !st.go_instr && !last_pulse)
      |=> (st.pulse == $past(st.pulse) + 12'h001) && (state == DCS_HOLD))
      else $error("clock step did not advance one pulse");
endmodule

/* File: dcs_host_model.sv */
module dcs_host
   import dcs_pkg::*;
(
   // clock
   input  wire logic        clk,
   // function channel towards the device
   output      logic        fn_valid,
   output      logic [7:0]  fn_code,
   output      logic [7:0]  fn_reg,
   output      dcs_word_t   fn_data,
   input  wire logic        fn_reply,
   input  wire logic        fn_reject,
   input  wire dcs_word_t   fn_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle channel at time zero
   initial begin
      fn_valid = 1'b0;
      fn_code  = 8'h00;
      fn_reg   = 8'h00;
      fn_data  = 16'h0000;
   end

   // one request, one-cycle strobe; the answer stands for one cycle after the request edge
   task automatic xfer(input logic [7:0] code, input logic [7:0] rg, input dcs_word_t wd,
                       output dcs_word_t rd, output logic [1:0] ans);
      @(negedge clk);
      fn_valid = 1'b1;
      fn_code  = code;
      fn_reg   = rg;
      fn_data  = wd;
      @(negedge clk);
      // reply and reject are single-cycle pulses, so take them before the next edge
      ans = {fn_reject, fn_reply};
      rd  = fn_rdata;
      // released lines flip so stale values cannot pass for good ones
      fn_valid = 1'b0;
      fn_code  = ~code;
      fn_reg   = ~rg;
      fn_data  = ~wd;
   endtask
endmodule

/* File: tb_top.sv */
`include "dcs_params.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dcs_pkg::*;

   logic        clk;
   logic        rst_n;
   logic        fn_valid;
   logic [7:0]  fn_code;
   logic [7:0]  fn_reg;
   dcs_word_t   fn_data;
   logic        fn_reply;
   logic        fn_reject;
   dcs_word_t   fn_rdata;
   logic [15:6] src_event;
   dcs_word_t   kbd_code;
   logic        irq;
   int          failures;
   int          compares;
   int          i;
   int          j;
   dcs_word_t   rd;
   dcs_word_t   pat;
   logic [1:0]  ans;

   dcs_ctrl dcs_ctrl_i (.clk(clk), .rst_n(rst_n), .fn_valid(fn_valid), .fn_code(fn_code),
      .fn_reg(fn_reg), .fn_data(fn_data), .fn_reply(fn_reply), .fn_reject(fn_reject),
      .fn_rdata(fn_rdata), .src_event(src_event), .kbd_code(kbd_code), .irq(irq));

   dcs_host dcs_host_i (.clk(clk), .fn_valid(fn_valid), .fn_code(fn_code), .fn_reg(fn_reg),
      .fn_data(fn_data), .fn_reply(fn_reply), .fn_reject(fn_reject), .fn_rdata(fn_rdata));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input string name, input dcs_word_t seen, input dcs_word_t exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // answer code is {reject, reply}
   task automatic acc(input logic [7:0] code, input logic [7:0] rg, input dcs_word_t wd,
                      input logic [1:0] exp);
      dcs_host_i.xfer(code, rg, wd, rd, ans);
      check("answer", {14'h0000, ans}, {14'h0000, exp});
   endtask

   task automatic rdreg(input logic [7:0] rg, input dcs_word_t exp);
      acc(`DCS_FN_UNLOAD, rg, 16'h0000, 2'b01);
      check("rdata", rd, exp);
   endtask

   task automatic wrreg(input logic [7:0] rg, input dcs_word_t wd);
      acc(`DCS_FN_LOAD, rg, wd, 2'b01);
   endtask

   // a rising edge on one source pin, then time for the synchroniser
   task automatic raise(input int b);
      @(negedge clk);
      src_event[b] = 1'b1;
      repeat (2) @(negedge clk);
      src_event[b] = 1'b0;
      repeat (4) @(negedge clk);
   endtask

   task automatic chk_irq(input logic exp);
      check("irq", {15'h0000, irq}, {15'h0000, exp});
   endtask

   // bounded wait for step completion seen on the request line
   task automatic wait_irq();
      for (int k = 0; k < 60 && irq !== 1'b1; k++) @(negedge clk);
      chk_irq(1'b1);
   endtask

   task automatic summarize();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // watchdog, far beyond the roughly 630 transfers of the run
   initial begin
      #400000;
      failures++;
      $display("Error watchdog expected finish seen hang");
      summarize();
   end

   initial begin
      failures = 0;
      compares = 0;
      rst_n = 1'b0;
      src_event = '0;
      kbd_code = 16'h5A3C;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      rdreg(`DCS_REG_ENABLE, 16'h0000);
      rdreg(`DCS_REG_STATUS, 16'h0000);
      $display("test reset values done");

      // all ones, all zeros, then a walking one through every register
      for (j = 0; j < 18; j++) begin
         pat = (j == 0) ? 16'hFFFF : (j == 1) ? 16'h0000 : 16'h0001 << (j - 2);
         for (i = 0; i < 16; i++) wrreg(i[7:0], pat);
         for (i = 0; i < 16; i++) rdreg(i[7:0], pat);
      end
      wrreg(8'h05, 16'hA5C3);
      rdreg(8'h05, 16'hA5C3);
      $display("test scratchpad done");

      // status, enable mask and the three clearing paths
      wrreg(`DCS_REG_ENABLE, 16'hEF9F);
      rdreg(`DCS_REG_ENABLE, 16'hEF80);
      raise(7);
      chk_irq(1'b1);
      rdreg(`DCS_REG_STATUS, 16'h0080);
      rdreg(`DCS_REG_STATUS, 16'h0000);
      chk_irq(1'b0);
      raise(15);
      rdreg(`DCS_REG_KEYBOARD, 16'h5A3C);
      rdreg(`DCS_REG_STATUS, 16'h0000);
      raise(9);
      acc(`DCS_FN_DISABLE, 8'h00, 16'h0200, 2'b01);
      rdreg(`DCS_REG_STATUS, 16'h0000);
      rdreg(`DCS_REG_ENABLE, 16'hED80);
      raise(9);
      chk_irq(1'b0);
      raise(13);
      chk_irq(1'b1);
      acc(`DCS_FN_RESET, 8'h00, 16'h0000, 2'b01);
      chk_irq(1'b0);
      rdreg(`DCS_REG_STATUS, 16'h0000);
      rdreg(`DCS_REG_ENABLE, 16'h0000);
      acc(`DCS_FN_LOAD, `DCS_REG_STATUS, 16'hFFFF, 2'b10);
      acc(8'h77, 8'h00, 16'h0000, 2'b10);
      rdreg(`DCS_REG_STATUS, 16'h0000);
      $display("test interrupt status done");

      // two-word instruction, clock stepped into word 1, then run out
      wrreg(`DCS_REG_ENABLE, 16'h0040);
      rdreg(`DCS_REG_STEP_POS, 16'hFFFF);
      wrreg(`DCS_REG_INSTR_BASE, 16'h8000);
      for (i = 0; i < 5; i++) begin
         acc(`DCS_FN_CLK_STEP, 8'h00, 16'h0000, 2'b01);
         rdreg(`DCS_REG_STEP_POS, (i < 4) ? i[15:0] : 16'h1000);
      end
      acc(`DCS_FN_INSTR_STEP, 8'h00, 16'h0000, 2'b01);
      wait_irq();
      rdreg(`DCS_REG_STEP_POS, 16'hFFFF);
      rdreg(`DCS_REG_STATUS, 16'h0040);
      chk_irq(1'b0);
      // length field zero still means one word
      wrreg(`DCS_REG_INSTR_BASE, 16'h0000);
      acc(`DCS_FN_INSTR_STEP, 8'h00, 16'h0000, 2'b01);
      wait_irq();
      rdreg(`DCS_REG_STATUS, 16'h0040);
      // three-word instruction, clock stepped into word 2, then run out
      wrreg(`DCS_REG_INSTR_BASE, 16'hC000);
      rdreg(`DCS_REG_INSTR_BASE, 16'hC000);
      for (i = 0; i < 9; i++) acc(`DCS_FN_CLK_STEP, 8'h00, 16'h0000, 2'b01);
      rdreg(`DCS_REG_STEP_POS, 16'h2000);
      acc(`DCS_FN_INSTR_STEP, 8'h00, 16'h0000, 2'b01);
      wait_irq();
      rdreg(`DCS_REG_STATUS, 16'h0040);
      $display("test stepping done");
      summarize();
   end
endmodule
